//--- core/sqd_defines.vh
// constants shared by the squib command decoder files
`ifndef SQD_DEFINES_VH
`define SQD_DEFINES_VH

// command codes
`define SQD_CMD_UNLOCK_CNT2 8'h81
`define SQD_CMD_UNLOCK_HS 8'h82
`define SQD_CMD_UNLOCK_LS 8'h83
`define SQD_CMD_LINK_CHECK 8'h96
`define SQD_CMD_STATUS 8'hc8
`define SQD_NIB_HS_TEST 4'h1
`define SQD_NIB_LS_TEST 4'h2
`define SQD_RESP_LINK_CHECK 8'h69
`define SQD_RESP_IDLE 8'h00

// apb register offsets
`define SQD_REG_CTRL 12'h000
`define SQD_REG_COUNTER 12'h004
`define SQD_REG_DRIVERS 12'h008
`define SQD_REG_STATUS 12'h00c
`define SQD_REG_IRQ_STAT 12'h010
`define SQD_REG_IRQ_EN 12'h014
`define SQD_REG_IRQ_CLR 12'h018
`define SQD_REG_TEST_RES 12'h01c

// interrupt status bit positions
`define SQD_EV_FRAME 0
`define SQD_EV_COUNTER 1
`define SQD_EV_HS_TEST 2
`define SQD_EV_LS_TEST 3
`define SQD_EV_NOP 4
`define SQD_EV_W 5

// ctrl register fields
`define SQD_CTRL_FIRING 0
`define SQD_CTRL_TEST_CLR 1

// reset values
`define SQD_COUNTER_RST 8'h00

`endif

//--- core/sqd_sync.v
// two-flop synchroniser for one level from outside the core clock domain
`timescale 1ns/1ns
module sqd_sync (
  input wire clk,    // core clock
  input wire rst_n,  // async reset, active low
  input wire d,      // asynchronous level
  output wire q      // synchronised level
);
  reg meta_r;
  reg sync_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule

//--- core/sqd_shifter.v
// spi mode 0 frame shifter sampled on the core clock
`timescale 1ns/1ns
module sqd_shifter #(
  parameter BITS = 8
) (
  input wire clk,             // core clock
  input wire rst_n,           // async reset, active low
  input wire sclk_s,          // synchronised serial clock
  input wire csn_s,           // synchronised chip select, active low
  input wire mosi_s,          // synchronised serial data in
  input wire [BITS-1:0] resp, // byte to send in the next frame
  output reg miso_r,          // serial data out
  output reg [BITS-1:0] rx_r, // last complete byte
  output reg rx_done_r        // one-cycle pulse per complete frame
);
  reg sclk_d_r;
  reg csn_d_r;
  reg [BITS-1:0] sh_r;
  reg [BITS-1:0] tx_r;
  reg [3:0] cnt_r;
  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire start = ~csn_s & csn_d_r;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      csn_d_r <= 1'b1;
      sh_r <= {BITS{1'b0}};
      tx_r <= {BITS{1'b0}};
      cnt_r <= 4'h0;
      miso_r <= 1'b0;
      rx_r <= {BITS{1'b0}};
      rx_done_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      csn_d_r <= csn_s;
      rx_done_r <= 1'b0;
      if (csn_s) begin
        cnt_r <= 4'h0;
      end else if (start) begin
        // response to the previous byte is loaded at frame start
        tx_r <= resp;
        miso_r <= resp[BITS-1];
        cnt_r <= 4'h0;
      end else if (rise) begin
        sh_r <= {sh_r[BITS-2:0], mosi_s};
        if (cnt_r == BITS - 1) begin
          rx_r <= {sh_r[BITS-2:0], mosi_s};
          rx_done_r <= 1'b1;
          cnt_r <= 4'h0;
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end else if (fall) begin
        tx_r <= {tx_r[BITS-2:0], 1'b0};
        miso_r <= tx_r[BITS-2];
      end
    end
  end
endmodule

//--- core/sqd_decoder.v
// squib driver serial command decoder with apb register view
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`include "sqd_defines.vh"
module sqd_decoder #(
  parameter BITS = 8
) (
  input wire CORE_CLK,           // core clock 125 MHz
  input wire RESETN,             // async reset, active low
  input wire SPI_SCLK,           // serial clock from host
  input wire SPI_CSN,            // chip select, active low
  input wire SPI_MOSI,           // serial data from host
  output reg SPI_MISO,           // serial data to host
  input wire FIRE_ENABLE_PIN_ONE, // first fire enable pin
  input wire FIRE_ENABLE_PIN_TWO, // second fire enable pin
  input wire LIMIT1_RES_FAULT,   // current-limit resistor 1 out of range
  input wire LIMIT2_RES_FAULT,   // current-limit resistor 2 out of range
  input wire DIAG_RES_FAULT,     // diagnostic reference resistor out of range
  input wire [3:0] HS_RESULT,    // high-side results 2b,2a,1b,1a
  input wire [3:0] LS_RESULT,    // low-side results 2b,2a,1b,1a
  output reg [3:0] HS_DRIVE_ON,  // high-side test drive 2b,2a,1b,1a
  output reg [3:0] LS_DRIVE_ON,  // low-side test drive 2b,2a,1b,1a
  output reg [7:0] SECOND_ENABLE_COUNTER, // programmed counter value
  output reg IRQ,                // level interrupt
  input wire PSEL,               // apb select
  input wire PENABLE,            // apb enable
  input wire PWRITE,             // apb direction
  input wire [11:0] PADDR,       // apb byte address
  input wire [31:0] PWDATA,      // apb write data
  output reg [31:0] PRDATA,      // apb read data
  output reg PREADY,             // apb ready
  output reg PSLVERR             // apb error
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_CNT = 4'b0010;
  localparam ST_HS = 4'b0100;
  localparam ST_LS = 4'b1000;

  wire sclk_s;
  wire csn_s;
  wire mosi_s;
  wire fen1_s;
  wire fen2_s;
  wire lim1_f_s;
  wire lim2_f_s;
  wire diag_f_s;
  wire miso_w;
  wire [BITS-1:0] rx_w;
  wire rx_done_w;

  reg [3:0] state_r;
  reg [3:0] state_nxt;
  reg [BITS-1:0] resp_r;
  reg [BITS-1:0] resp_nxt;
  reg [BITS-1:0] cnt_nxt;
  reg [3:0] hs_nxt;
  reg [3:0] ls_nxt;
  reg [`SQD_EV_W-1:0] ev_nxt;
  reg fen1_latch_r;
  reg fen2_latch_r;
  reg [1:0] ctrl_r;
  reg [`SQD_EV_W-1:0] irq_stat_r;
  reg [`SQD_EV_W-1:0] irq_en_r;
  reg [3:0] hs_res_r;
  reg [3:0] ls_res_r;
  reg [7:0] last_cmd_r;

  wire [7:0] hs_res_s;
  wire cs_act_s;

  sqd_sync u_sclk (.clk(CORE_CLK), .rst_n(RESETN), .d(SPI_SCLK), .q(sclk_s));
  // select is synchronised active high so the flops' reset value means idle,
  // otherwise a false frame start would follow every reset
  sqd_sync u_csn (.clk(CORE_CLK), .rst_n(RESETN), .d(~SPI_CSN), .q(cs_act_s));
  assign csn_s = ~cs_act_s;
  sqd_sync u_mosi (.clk(CORE_CLK), .rst_n(RESETN), .d(SPI_MOSI), .q(mosi_s));
  sqd_sync u_fen1 (.clk(CORE_CLK), .rst_n(RESETN), .d(FIRE_ENABLE_PIN_ONE), .q(fen1_s));
  sqd_sync u_fen2 (.clk(CORE_CLK), .rst_n(RESETN), .d(FIRE_ENABLE_PIN_TWO), .q(fen2_s));
  sqd_sync u_l1 (.clk(CORE_CLK), .rst_n(RESETN), .d(LIMIT1_RES_FAULT), .q(lim1_f_s));
  sqd_sync u_l2 (.clk(CORE_CLK), .rst_n(RESETN), .d(LIMIT2_RES_FAULT), .q(lim2_f_s));
  sqd_sync u_dg (.clk(CORE_CLK), .rst_n(RESETN), .d(DIAG_RES_FAULT), .q(diag_f_s));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_res
      sqd_sync u_hs (.clk(CORE_CLK), .rst_n(RESETN), .d(HS_RESULT[gi]), .q(hs_res_s[gi]));
      sqd_sync u_ls (.clk(CORE_CLK), .rst_n(RESETN), .d(LS_RESULT[gi]),
        .q(hs_res_s[gi+4]));
    end
  endgenerate

  sqd_shifter #(.BITS(BITS)) u_shift (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .sclk_s(sclk_s),
    .csn_s(csn_s),
    .mosi_s(mosi_s),
    .resp(resp_r),
    .miso_r(miso_w),
    .rx_r(rx_w),
    .rx_done_r(rx_done_w)
  );

  // firing flag stands for any output switch firing; set by software
  wire firing_w = ctrl_r[`SQD_CTRL_FIRING];
  // resistor ok flags: any fault mode (open, ground, supply) arrives as one fault level
  wire [7:0] status_w = {1'b1, ~lim2_f_s, ~lim1_f_s, ~diag_f_s,
    fen2_latch_r, fen1_latch_r, fen2_s, fen1_s};

  always @* begin
    state_nxt = ST_IDLE;
    resp_nxt = `SQD_RESP_IDLE;
    cnt_nxt = SECOND_ENABLE_COUNTER;
    hs_nxt = HS_DRIVE_ON;
    ls_nxt = LS_DRIVE_ON;
    ev_nxt = {`SQD_EV_W{1'b0}};
    ev_nxt[`SQD_EV_FRAME] = 1'b1;
    case (state_r)
      ST_CNT: begin
        if (firing_w) begin
          ev_nxt[`SQD_EV_NOP] = 1'b1;
        end else begin
          cnt_nxt = rx_w;
          resp_nxt = rx_w;
          ev_nxt[`SQD_EV_COUNTER] = 1'b1;
        end
      end
      ST_HS: begin
        if (firing_w || rx_w[7:4] != `SQD_NIB_HS_TEST) begin
          ev_nxt[`SQD_EV_NOP] = 1'b1;
        end else begin
          hs_nxt = rx_w[3:0];
          resp_nxt = {4'h0, hs_res_r & rx_w[3:0]};
          ev_nxt[`SQD_EV_HS_TEST] = 1'b1;
        end
      end
      ST_LS: begin
        if (firing_w || rx_w[7:4] != `SQD_NIB_LS_TEST) begin
          ev_nxt[`SQD_EV_NOP] = 1'b1;
        end else begin
          ls_nxt = rx_w[3:0];
          resp_nxt = {4'h0, ls_res_r & rx_w[3:0]};
          ev_nxt[`SQD_EV_LS_TEST] = 1'b1;
        end
      end
      default: begin
        case (rx_w)
          `SQD_CMD_UNLOCK_CNT2: begin
            state_nxt = ST_CNT;
            resp_nxt = rx_w;
          end
          `SQD_CMD_UNLOCK_HS: begin
            state_nxt = ST_HS;
            resp_nxt = rx_w;
          end
          `SQD_CMD_UNLOCK_LS: begin
            state_nxt = ST_LS;
            resp_nxt = rx_w;
          end
          `SQD_CMD_LINK_CHECK: resp_nxt = `SQD_RESP_LINK_CHECK;
          `SQD_CMD_STATUS: resp_nxt = status_w;
          default: resp_nxt = `SQD_RESP_IDLE;
        endcase
      end
    endcase
  end

  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= ST_IDLE;
      resp_r <= `SQD_RESP_IDLE;
      SECOND_ENABLE_COUNTER <= `SQD_COUNTER_RST;
      HS_DRIVE_ON <= 4'h0;
      LS_DRIVE_ON <= 4'h0;
      SPI_MISO <= 1'b0;
      fen1_latch_r <= 1'b0;
      fen2_latch_r <= 1'b0;
      hs_res_r <= 4'h0;
      ls_res_r <= 4'h0;
      last_cmd_r <= 8'h00;
      irq_stat_r <= {`SQD_EV_W{1'b0}};
      IRQ <= 1'b0;
    end else begin
      SPI_MISO <= miso_w;
      hs_res_r <= hs_res_s[3:0];
      ls_res_r <= hs_res_s[7:4];
      // latches catch any assertion of the enable pins since reset
      fen1_latch_r <= fen1_latch_r | fen1_s;
      fen2_latch_r <= fen2_latch_r | fen2_s;
      if (ctrl_r[`SQD_CTRL_TEST_CLR]) begin
        HS_DRIVE_ON <= 4'h0;
        LS_DRIVE_ON <= 4'h0;
      end
      if (rx_done_w) begin
        state_r <= state_nxt;
        resp_r <= resp_nxt;
        SECOND_ENABLE_COUNTER <= cnt_nxt;
        HS_DRIVE_ON <= hs_nxt;
        LS_DRIVE_ON <= ls_nxt;
        last_cmd_r <= rx_w;
      end
      // set wins over a same-cycle clear
      irq_stat_r <= (irq_stat_r & ~(PSEL && PENABLE && PWRITE && PADDR == `SQD_REG_IRQ_CLR
        ? PWDATA[`SQD_EV_W-1:0] : {`SQD_EV_W{1'b0}})) | (rx_done_w ? ev_nxt : {`SQD_EV_W{1'b0}});
      IRQ <= |(irq_stat_r & irq_en_r);
    end
  end

  // apb slave: zero wait states, unmapped address answers pslverr
  reg mapped_w;
  always @* begin
    case (PADDR)
      `SQD_REG_CTRL, `SQD_REG_COUNTER, `SQD_REG_DRIVERS, `SQD_REG_STATUS,
      `SQD_REG_IRQ_STAT, `SQD_REG_IRQ_EN, `SQD_REG_IRQ_CLR, `SQD_REG_TEST_RES:
        mapped_w = 1'b1;
      default: mapped_w = 1'b0;
    endcase
  end

  always @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctrl_r <= 2'b00;
      irq_en_r <= {`SQD_EV_W{1'b0}};
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped_w;
      if (PSEL && PENABLE && PWRITE) begin
        if (PADDR == `SQD_REG_CTRL) ctrl_r <= PWDATA[1:0];
        if (PADDR == `SQD_REG_IRQ_EN) irq_en_r <= PWDATA[`SQD_EV_W-1:0];
      end
      PRDATA <= 32'h00000000;
      if (PSEL && !PENABLE && !PWRITE) begin
        case (PADDR)
          `SQD_REG_CTRL: PRDATA <= {30'h0, ctrl_r};
          `SQD_REG_COUNTER: PRDATA <= {24'h0, SECOND_ENABLE_COUNTER};
          `SQD_REG_DRIVERS: PRDATA <= {24'h0, LS_DRIVE_ON, HS_DRIVE_ON};
          `SQD_REG_STATUS: PRDATA <= {16'h0, last_cmd_r, status_w};
          `SQD_REG_IRQ_STAT: PRDATA <= {27'h0, irq_stat_r};
          `SQD_REG_IRQ_EN: PRDATA <= {27'h0, irq_en_r};
          `SQD_REG_TEST_RES: PRDATA <= {24'h0, ls_res_r, hs_res_r};
          default: PRDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

//--- testbench/sqd_decoder_assertions.sv
// port-level assertion checker for the squib command decoder
`timescale 1ns/1ns
module sqd_decoder_checker (
  input wire CORE_CLK, // core clock
  input wire RESETN, // async reset, active low
  input wire SPI_SCLK, // serial clock
  input wire SPI_CSN, // chip select, active low
  input wire SPI_MISO, // serial data out
  input wire [3:0] HS_DRIVE_ON, // high-side drives
  input wire [3:0] LS_DRIVE_ON, // low-side drives
  input wire [7:0] SECOND_ENABLE_COUNTER, // counter value
  input wire PSEL, // apb select
  input wire PENABLE, // apb enable
  input wire [11:0] PADDR, // apb address
  input wire [31:0] PRDATA, // apb read data
  input wire PREADY, // apb ready
  input wire PSLVERR // apb error
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  sequence setup_s;
    PSEL && !PENABLE;
  endsequence
  sequence answer_s;
    PSEL && PENABLE && PREADY;
  endsequence
  apb_answer_a: assert property (setup_s |=> answer_s)
    else $error("apb setup not answered next cycle");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE && $past(PSEL && !PENABLE))
    else $error("ready outside a zero-wait access");
  unmapped_err_a: assert property (PREADY && PADDR > 12'h01c |-> PSLVERR)
    else $error("unmapped access without error");
  err_data_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  miso_hold_a: assert property ($rose(SPI_SCLK) |=> $stable(SPI_MISO)[*6])
    else $error("serial output moved while clock high");
  counter_frame_a: assert property ($changed(SECOND_ENABLE_COUNTER) |-> !SPI_CSN)
    else $error("counter changed outside a frame");
  hs_cause_a: assert property ($changed(HS_DRIVE_ON) |-> !SPI_CSN || $past(PREADY, 2))
    else $error("high-side drive changed without cause");
  ls_cause_a: assert property ($changed(LS_DRIVE_ON) |-> !SPI_CSN || $past(PREADY, 2))
    else $error("low-side drive changed without cause");
endmodule
bind sqd_decoder sqd_decoder_checker chk_u (
  .CORE_CLK(CORE_CLK), .RESETN(RESETN), .SPI_SCLK(SPI_SCLK), .SPI_CSN(SPI_CSN),
  .SPI_MISO(SPI_MISO), .HS_DRIVE_ON(HS_DRIVE_ON), .LS_DRIVE_ON(LS_DRIVE_ON),
  .SECOND_ENABLE_COUNTER(SECOND_ENABLE_COUNTER), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR)
);

//--- testbench/sqd_host_model.sv
// serial host model: mode 0 master, clock still between frames
`timescale 1ns/1ns
module sqd_host_model (
  output logic sclk, // serial clock
  output logic csn, // chip select, active low
  output logic mosi, // data to device
  input wire miso // data from device
);
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end
  // reply seen here belongs to the previous byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    #3 csn = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #80 sclk = 1'b1;
      rx[i] = miso;
      #80 sclk = 1'b0;
    end
    #40 csn = 1'b1;
    mosi = ~mosi; // released line must not keep the last bit
    #200;
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the squib command decoder
`timescale 1ns/1ns
`include "sqd_defines.vh"
module tb;
  logic clk = 1'b0, rst_n = 1'b0, sclk, csn, mosi, miso, irq, pready, pslverr, err;
  logic fen1 = 1'b0, fen2 = 1'b0, lim1 = 1'b0, lim2 = 1'b0, diag = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [3:0] hs_res = 4'h0, ls_res = 4'h0, hs_on, ls_on;
  logic [7:0] cnt;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int err_count = 0, check_count = 0, cycles = 0;
  sqd_decoder dut_u (
    .CORE_CLK(clk), .RESETN(rst_n), .SPI_SCLK(sclk), .SPI_CSN(csn), .SPI_MOSI(mosi),
    .SPI_MISO(miso), .FIRE_ENABLE_PIN_ONE(fen1), .FIRE_ENABLE_PIN_TWO(fen2),
    .LIMIT1_RES_FAULT(lim1), .LIMIT2_RES_FAULT(lim2), .DIAG_RES_FAULT(diag),
    .HS_RESULT(hs_res), .LS_RESULT(ls_res), .HS_DRIVE_ON(hs_on), .LS_DRIVE_ON(ls_on),
    .SECOND_ENABLE_COUNTER(cnt), .IRQ(irq), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr)
  );
  sqd_host_model host_u (.sclk(sclk), .csn(csn), .mosi(mosi), .miso(miso));
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // no scenario sends the reserved factory codes 0x90 to 0x93
  task automatic spi(input logic [7:0] tx, input logic [7:0] exp);
    logic [7:0] rx;
    host_u.xfer(tx, rx);
    chk(rx, exp, "reply");
  endtask
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    chk(irq, exp, "irq");
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("FAIL %0t timeout", $time);
      report_and_stop();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b1, `SQD_REG_IRQ_EN, 32'h2);
    spi(8'h96, 8'h00);
    spi(8'h00, 8'h69);
    $display("test link done");
    spi(8'h81, 8'h00);
    spi(8'ha5, 8'h81);
    spi(8'h00, 8'ha5);
    chk(cnt, 32'ha5, "counter");
    irq_is(1'b1);
    apb(1'b1, `SQD_REG_IRQ_EN, 32'h0);
    irq_is(1'b0);
    apb(1'b1, `SQD_REG_IRQ_EN, 32'h2);
    irq_is(1'b1);
    apb(1'b1, `SQD_REG_IRQ_CLR, 32'h2);
    irq_is(1'b0);
    apb(1'b0, `SQD_REG_COUNTER, 32'h0);
    chk(rd, 32'ha5, "counter read");
    apb(1'b0, 12'h020, 32'h0);
    chk(err, 32'h1, "unmapped");
    $display("test counter done");
    // the frame right after an unlock is its value; a later byte programs nothing
    spi(8'h81, 8'h00);
    spi(8'h96, 8'h81);
    spi(8'h3c, 8'h96);
    spi(8'h00, 8'h00);
    chk(cnt, 32'h96, "gap");
    apb(1'b1, `SQD_REG_CTRL, 32'h1);
    spi(8'h81, 8'h00);
    spi(8'h5a, 8'h81);
    spi(8'h00, 8'h00);
    apb(1'b1, `SQD_REG_CTRL, 32'h0);
    chk(cnt, 32'h96, "firing");
    $display("test nop done");
    @(posedge clk);
    hs_res <= 4'ha;
    ls_res <= 4'h6;
    spi(8'h82, 8'h00);
    spi(8'h1f, 8'h82);
    chk(hs_on, 32'hf, "hs drive");
    spi(8'h83, 8'h0a);
    spi(8'h25, 8'h83);
    chk(ls_on, 32'h5, "ls drive");
    spi(8'h82, 8'h04);
    spi(8'h21, 8'h82);
    spi(8'h13, 8'h00);
    spi(8'h00, 8'h00);
    chk({hs_on, ls_on}, 32'hf5, "drives kept");
    apb(1'b1, `SQD_REG_CTRL, 32'h2);
    repeat (2) @(posedge clk);
    chk({hs_on, ls_on}, 32'h00, "drives cleared");
    apb(1'b1, `SQD_REG_CTRL, 32'h0);
    $display("test drivers done");
    @(posedge clk);
    fen1 <= 1'b1;
    lim1 <= 1'b1;
    spi(8'hc8, 8'h00);
    spi(8'hc8, 8'hd5);
    @(posedge clk);
    fen1 <= 1'b0;
    fen2 <= 1'b1;
    lim1 <= 1'b0;
    lim2 <= 1'b1;
    diag <= 1'b1;
    spi(8'h00, 8'hd5);
    spi(8'hc8, 8'h00);
    spi(8'h00, 8'hae);
    $display("test status done");
    report_and_stop();
  end
endmodule
